// ===== lvil_consts.vh
// Constants for the low-voltage inhibit logic
`ifndef LVIL_CONSTS_VH
`define LVIL_CONSTS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define LVIL_OFS_CONFIG 8'h00
`define LVIL_OFS_STATUS 8'h04
`define LVIL_OFS_EVENT 8'h08
`define LVIL_OFS_MASK 8'h0C

// ****************************************
// Field positions and reset values
// ****************************************
`define LVIL_CFG_PWR 0
`define LVIL_CFG_RST 1
`define LVIL_CFG_STOP 2
`define LVIL_CFG_W 3
`define LVIL_CFG_RESET 3'h3
`define LVIL_ST_FLAG 0
`define LVIL_ST_TRIP 1
`define LVIL_ST_ACTIVE 2
`define LVIL_ST_BELOW 3
`define LVIL_ST_ABOVE 4
`define LVIL_EV_TRIP 0
`define LVIL_EV_FLAG 1
`define LVIL_EV_RELEASE 2
`define LVIL_EV_W 3
`define LVIL_EV_RESET 3'h0
`define LVIL_MASK_RESET 3'h0

// ****************************************
// Timing counts
// ****************************************
`define LVIL_FILTER_CYCLES 4'h9
`define LVIL_FLAG_MIN_CYCLES 6'h20
`define LVIL_FLAG_MAX_CYCLES 6'h28
`define LVIL_FLAG_SET_CYCLES 6'h24

// ****************************************
// Bus answers
// ****************************************
`define LVIL_RESP_OKAY 2'h0
`define LVIL_RESP_SLVERR 2'h2

`endif

// ===== lvil_core.v
// Low-voltage inhibit logic: supply filter, forced reset, flag and register slave
`include "lvil_consts.vh"
`default_nettype none

module lvil_core #(
	parameter ADDR_W = 8,
	parameter [3:0] FILTER_CYCLES = `LVIL_FILTER_CYCLES,
	parameter [5:0] FLAG_SET_CYCLES = `LVIL_FLAG_SET_CYCLES
) (
	input wire ref_clk_i, // 100 MHz clock
	input wire rst_i, // Synchronous reset, active high
	input wire clk_en_i, // Freezes all state while low
	input wire cpu_cycle_i, // One-cycle strobe per CPU cycle
	input wire xtal_tick_i, // One-cycle strobe per crystal clock cycle
	input wire wait_mode_i, // Processor in wait mode
	input wire stop_mode_i, // Processor in stop mode
	input wire sys_reset_i, // Any other chip reset source active
	input wire below_falling_i, // Comparator: supply at or below falling level
	input wire above_rising_i, // Comparator: supply above rising level
	output wire monitor_power_o, // Powers the comparator and reference
	output reg chip_reset_o, // Forced low-voltage reset
	output wire reset_pin_o, // Reset pin output level
	output wire reset_pin_oe_o, // Reset pin drive enable
	output reg irq_o, // Supervisor event line to the system controller
	input wire [ADDR_W-1:0] s_axi_awaddr_i, // Write address
	input wire s_axi_awvalid_i, // Write address valid
	output wire s_axi_awready_o, // Write address ready
	input wire [31:0] s_axi_wdata_i, // Write data
	input wire [3:0] s_axi_wstrb_i, // Write byte strobes
	input wire s_axi_wvalid_i, // Write data valid
	output wire s_axi_wready_o, // Write data ready
	output reg [1:0] s_axi_bresp_o, // Write response
	output reg s_axi_bvalid_o, // Write response valid
	input wire s_axi_bready_i, // Write response ready
	input wire [ADDR_W-1:0] s_axi_araddr_i, // Read address
	input wire s_axi_arvalid_i, // Read address valid
	output wire s_axi_arready_o, // Read address ready
	output reg [31:0] s_axi_rdata_o, // Read data
	output reg [1:0] s_axi_rresp_o, // Read response
	output reg s_axi_rvalid_o, // Read data valid
	input wire s_axi_rready_i // Read data ready
);

	// ****************************************
	// Declarations
	// ****************************************
	reg [2:0] below_sync_reg;
	reg [2:0] above_sync_reg;
	reg below_reg;
	reg above_reg;
	reg [`LVIL_CFG_W-1:0] cfg_reg;
	reg [`LVIL_EV_W-1:0] event_reg;
	reg [`LVIL_EV_W-1:0] event_next;
	reg [`LVIL_EV_W-1:0] mask_reg;
	wire filt_done;
	wire flag_done;
	reg flag_reg;
	reg flag_next;
	reg trip_next;
	reg aw_hold_reg;
	reg [ADDR_W-1:0] aw_addr_reg;
	reg w_hold_reg;
	reg [31:0] w_data_reg;
	reg w_strb0_reg;
	reg [31:0] rd_data;
	reg rd_hit;
	wire pwr_en;
	wire rst_en;
	wire stop_en;
	wire active;
	wire reset_armed;
	wire stop_bypass;
	wire any_reset;
	wire wr_fire;
	wire wr_hit;
	wire ar_fire;
	wire ev_read;
	wire [`LVIL_EV_W-1:0] ev_set;

	assign pwr_en = cfg_reg[`LVIL_CFG_PWR];
	assign rst_en = cfg_reg[`LVIL_CFG_RST];
	assign stop_en = cfg_reg[`LVIL_CFG_STOP];

	// ****************************************
	// Comparator synchronisers
	// ****************************************
	// The comparator outputs are analog and asynchronous; a new level is
	// accepted only when the second and third stages agree.
	always @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			below_sync_reg <= 3'h0;
			above_sync_reg <= 3'h0;
			below_reg <= 1'b0;
			above_reg <= 1'b0;
		end
		else if (clk_en_i)
		begin
			below_sync_reg <= {below_sync_reg[1:0], below_falling_i};
			above_sync_reg <= {above_sync_reg[1:0], above_rising_i};
			if (below_sync_reg[1] == below_sync_reg[2])
				below_reg <= below_sync_reg[2];
			if (above_sync_reg[1] == above_sync_reg[2])
				above_reg <= above_sync_reg[2];
		end
	end

	// ****************************************
	// Monitor enables
	// ****************************************
	// Wait mode does not enter this term: the monitor keeps running there.
	assign active = pwr_en & (~stop_mode_i | stop_en);
	assign reset_armed = active & rst_en;
	// CPU cycles stop in stop mode, so the filter could never complete there.
	assign stop_bypass = reset_armed & stop_mode_i & below_reg;
	assign monitor_power_o = pwr_en;
	assign any_reset = sys_reset_i | chip_reset_o;

	// ****************************************
	// Reset filter and forced reset
	// ****************************************
	always @*
	begin
		trip_next = chip_reset_o;
		if (chip_reset_o)
		begin
			// One cycle above the rising level releases; stop has no CPU cycles
			if (above_reg && (cpu_cycle_i || stop_mode_i))
				trip_next = 1'b0;
		end
		else if (reset_armed && filt_done)
			trip_next = 1'b1;
		else if (stop_bypass)
			trip_next = 1'b1;
	end

	// Restarts whenever the supply is seen back above the falling level
	lvil_run_cnt #(
		.W(4),
		.LIMIT(FILTER_CYCLES)
	) u_filt_cnt (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.clk_en_i(clk_en_i),
		.run_i(active & below_reg),
		.tick_i(cpu_cycle_i),
		.cnt_o(),
		.done_o(filt_done)
	);

	always @(posedge ref_clk_i)
	begin
		if (rst_i)
			chip_reset_o <= 1'b0;
		else if (clk_en_i)
			chip_reset_o <= trip_next;
	end

	// Open-drain pin: only ever pulled low, and only during a forced reset
	assign reset_pin_o = 1'b0;
	assign reset_pin_oe_o = chip_reset_o;

	// ****************************************
	// Low-voltage flag
	// ****************************************
	// Fed straight from the comparator level so polling works without resets.
	always @*
	begin
		flag_next = flag_reg;
		if (any_reset)
			flag_next = 1'b0;
		else if (above_reg)
			flag_next = 1'b0;
		else if (below_reg && flag_done)
			flag_next = 1'b1;
	end

	lvil_run_cnt #(
		.W(6),
		.LIMIT(FLAG_SET_CYCLES)
	) u_flag_cnt (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.clk_en_i(clk_en_i),
		.run_i(active & below_reg),
		.tick_i(xtal_tick_i),
		.cnt_o(),
		.done_o(flag_done)
	);

	always @(posedge ref_clk_i)
	begin
		if (rst_i)
			flag_reg <= 1'b0;
		else if (clk_en_i)
			flag_reg <= flag_next;
	end

	// ****************************************
	// Event status and system event line
	// ****************************************
	// This line goes to the system controller, never to the CPU interrupt logic.
	assign ev_set[`LVIL_EV_TRIP] = trip_next & ~chip_reset_o;
	assign ev_set[`LVIL_EV_FLAG] = flag_next & ~flag_reg;
	assign ev_set[`LVIL_EV_RELEASE] = chip_reset_o & ~trip_next;

	always @*
	begin
		event_next = event_reg;
		if (ev_read)
			event_next = {`LVIL_EV_W{1'b0}};
		// A new event in the clearing cycle survives the read
		event_next = event_next | ev_set;
	end

	always @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			event_reg <= `LVIL_EV_RESET;
			irq_o <= 1'b0;
		end
		else if (clk_en_i)
		begin
			event_reg <= event_next;
			irq_o <= |(event_next & mask_reg);
		end
	end

	// ****************************************
	// Register slave
	// ****************************************
	// Ready drops with the clock enable so no handshake is taken while frozen.
	assign s_axi_awready_o = ~aw_hold_reg & clk_en_i;
	assign s_axi_wready_o = ~w_hold_reg & clk_en_i;
	assign s_axi_arready_o = ~s_axi_rvalid_o & clk_en_i;
	assign wr_fire = aw_hold_reg & w_hold_reg & ~s_axi_bvalid_o;
	assign wr_hit = aw_addr_reg == `LVIL_OFS_CONFIG || aw_addr_reg == `LVIL_OFS_MASK;
	assign ar_fire = s_axi_arvalid_i & s_axi_arready_o;
	assign ev_read = ar_fire & (s_axi_araddr_i == `LVIL_OFS_EVENT);

	always @*
	begin
		rd_data = 32'h0000_0000;
		rd_hit = 1'b1;
		case (s_axi_araddr_i)
			`LVIL_OFS_CONFIG:
				rd_data[`LVIL_CFG_W-1:0] = cfg_reg;
			`LVIL_OFS_STATUS:
			begin
				rd_data[`LVIL_ST_FLAG] = flag_reg;
				rd_data[`LVIL_ST_TRIP] = chip_reset_o;
				rd_data[`LVIL_ST_ACTIVE] = active;
				rd_data[`LVIL_ST_BELOW] = below_reg;
				rd_data[`LVIL_ST_ABOVE] = above_reg;
			end
			`LVIL_OFS_EVENT:
				rd_data[`LVIL_EV_W-1:0] = event_reg;
			`LVIL_OFS_MASK:
				rd_data[`LVIL_EV_W-1:0] = mask_reg;
			default:
				rd_hit = 1'b0;
		endcase
	end

	always @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			cfg_reg <= `LVIL_CFG_RESET;
			mask_reg <= `LVIL_MASK_RESET;
			aw_hold_reg <= 1'b0;
			aw_addr_reg <= {ADDR_W{1'b0}};
			w_hold_reg <= 1'b0;
			w_data_reg <= 32'h0000_0000;
			w_strb0_reg <= 1'b0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= `LVIL_RESP_OKAY;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rresp_o <= `LVIL_RESP_OKAY;
			s_axi_rdata_o <= 32'h0000_0000;
		end
		else if (clk_en_i)
		begin
			if (s_axi_awvalid_i && s_axi_awready_o)
			begin
				aw_hold_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && s_axi_wready_o)
			begin
				w_hold_reg <= 1'b1;
				w_data_reg <= s_axi_wdata_i;
				w_strb0_reg <= s_axi_wstrb_i[0];
			end
			if (wr_fire)
			begin
				aw_hold_reg <= 1'b0;
				w_hold_reg <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o <= wr_hit ? `LVIL_RESP_OKAY : `LVIL_RESP_SLVERR;
				// All fields sit in byte lane 0
				if (w_strb0_reg && aw_addr_reg == `LVIL_OFS_CONFIG)
					cfg_reg <= w_data_reg[`LVIL_CFG_W-1:0];
				if (w_strb0_reg && aw_addr_reg == `LVIL_OFS_MASK)
					mask_reg <= w_data_reg[`LVIL_EV_W-1:0];
			end
			else if (s_axi_bvalid_o && s_axi_bready_i)
				s_axi_bvalid_o <= 1'b0;
			if (ar_fire)
			begin
				s_axi_rvalid_o <= 1'b1;
				s_axi_rdata_o <= rd_data;
				s_axi_rresp_o <= rd_hit ? `LVIL_RESP_OKAY : `LVIL_RESP_SLVERR;
			end
			else if (s_axi_rvalid_o && s_axi_rready_i)
				s_axi_rvalid_o <= 1'b0;
		end
	end

endmodule

// ****************************************
// Run-length counter
// ****************************************
// Saturates at its limit so a long low spell cannot wrap and lose the trip.
module lvil_run_cnt #(
	parameter W = 4,
	parameter [W-1:0] LIMIT = {W{1'b1}}
) (
	input wire ref_clk_i, // Clock
	input wire rst_i, // Synchronous reset, active high
	input wire clk_en_i, // Freezes the count while low
	input wire run_i, // Count allowed; low restarts from zero
	input wire tick_i, // One-cycle count strobe
	output reg [W-1:0] cnt_o, // Current count
	output wire done_o // Count has reached the limit
);

	assign done_o = cnt_o == LIMIT;

	always @(posedge ref_clk_i)
	begin
		if (rst_i)
			cnt_o <= {W{1'b0}};
		else if (clk_en_i)
		begin
			if (!run_i)
				cnt_o <= {W{1'b0}};
			else if (tick_i && !done_o)
				cnt_o <= cnt_o + {{(W-1){1'b0}}, 1'b1};
		end
	end

endmodule

`default_nettype wire

// ===== lvil_monitor.sv
// Checker of the low-voltage inhibit ports
`default_nettype none
module lvil_monitor #(
	parameter [3:0] FILTER_CYCLES = 4'h9
) (
	input wire ref_clk_i, // Clock
	input wire rst_i, // Reset
	input wire clk_en_i, // Run
	input wire cpu_cycle_i, // CPU strobe
	input wire stop_mode_i, // Stop
	input wire below_falling_i, // Low
	input wire above_rising_i, // Good
	input wire monitor_power_o, // Power
	input wire chip_reset_o, // Forced reset
	input wire reset_pin_o, // Pin level
	input wire reset_pin_oe_o, // Pin drive
	input wire [1:0] s_axi_bresp_o, // Write answer
	input wire s_axi_bvalid_o, // Write valid
	input wire s_axi_bready_i, // Write ready
	input wire [31:0] s_axi_rdata_o, // Read data
	input wire s_axi_rvalid_o, // Read valid
	input wire s_axi_rready_i // Read ready
);
	// ********
	// Helpers
	// ********
	logic [7:0] low_cnt;
	logic [5:0] above_hist;
	// Counted before the synchroniser, so it leads the filter's own count unless a dip that never reaches below_reg clears it
	always @(posedge ref_clk_i)
	begin
		if (rst_i || !below_falling_i)
			low_cnt <= 8'h00;
		else if (clk_en_i && cpu_cycle_i && low_cnt != 8'hFF)
			low_cnt <= low_cnt + 8'h01;
		if (clk_en_i)
			above_hist <= {above_hist[4:0], above_rising_i};
	end
	// ********
	// Properties
	// ********
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);
	AST_PIN_DRIVE: assert property (reset_pin_oe_o == chip_reset_o && !reset_pin_o)
		else $error("Reset pin does not follow forced reset");
	AST_POWER_AT_RESET: assert property ($past(rst_i) |-> monitor_power_o)
		else $error("Monitor off after reset");
	AST_RISE_POWER: assert property ($rose(chip_reset_o) |-> $past(monitor_power_o))
		else $error("Reset without power enable");
	AST_RISE_FILTER: assert property ($rose(chip_reset_o) && !$past(stop_mode_i)
		|-> low_cnt >= {4'h0, FILTER_CYCLES}) else $error("Reset before filter count");
	AST_FALL_CPU: assert property ($fell(chip_reset_o) && !$past(rst_i)
		|-> $past(cpu_cycle_i) || $past(stop_mode_i)) else $error("Release without CPU cycle");
	AST_FALL_ABOVE: assert property ($fell(chip_reset_o) && !$past(rst_i)
		|-> above_hist != 6'h00) else $error("Release without good supply");
	AST_B_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i
		|=> s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("Write answer dropped");
	AST_R_HOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i
		|=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("Read answer dropped");
endmodule
`default_nettype wire

// ===== tb_top.sv
// Testbench of the low-voltage inhibit logic
`include "lvil_consts.vh"
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, rst, run_cpu, cpu, xtal, waitm, stopm, sysr, below, above;
	logic awvalid, wvalid, bready, arvalid, rready, clken;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rd_val;
	logic [3:0] wstrb;
	logic [1:0] resp;
	wire awready, wready, bvalid, arready, rvalid, chip_rst, pin, pin_oe, pwr, irq;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	integer seed;
	int miscompares, compares, n;
	lvil_core #(.ADDR_W(8)) DUT (.ref_clk_i(clk), .rst_i(rst), .clk_en_i(clken), .cpu_cycle_i(cpu),
	.xtal_tick_i(xtal), .wait_mode_i(waitm), .stop_mode_i(stopm), .sys_reset_i(sysr),
	.below_falling_i(below), .above_rising_i(above), .monitor_power_o(pwr),
	.chip_reset_o(chip_rst), .reset_pin_o(pin), .reset_pin_oe_o(pin_oe), .irq_o(irq),
	.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
	.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
	.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
	.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
	.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));
	// ********
	// Stimulus
	// ********
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Irregular strobes keep the filter from locking onto a fixed rate
	always @(posedge clk)
	begin
		cpu <= run_cpu & 1'($random(seed));
		xtal <= 2'($random(seed)) != 2'h0;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		{awaddr, wdata, awvalid, wvalid} <= {a, d, 2'b11};
		do
		begin
			@(posedge clk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (!bready)
				bready <= 1'($random(seed));
		end while (!(bvalid && bready));
		resp = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		{araddr, arvalid} <= {a, 1'b1};
		do
		begin
			@(posedge clk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (!rready)
				rready <= 1'($random(seed));
		end while (!(rvalid && rready));
		{rd_val, resp} = {rdata, rresp};
		rready <= 1'b0;
	endtask
	function automatic logic act(input logic [2:0] c, input logic st);
		return c[`LVIL_CFG_PWR] && (!st || c[`LVIL_CFG_STOP]);
	endfunction
	task automatic trip(input logic [2:0] c, input logic st);
		logic e;
		e = act(c, st) & c[`LVIL_CFG_RST];
		wr(`LVIL_OFS_CONFIG, 32'(c));
		chk("power", 32'(c[0]), 32'(pwr));
		{waitm, stopm, run_cpu, below} <= {1'($random(seed)), st, !st, 1'b1};
		repeat (100) @(posedge clk);
		chk("trip", 32'(e), 32'(chip_rst));
		chk("pin", {30'h0, e, 1'b0}, {30'h0, pin_oe, pin});
		rd(`LVIL_OFS_STATUS);
		chk("flag", 32'(act(c, st) & !c[1]), 32'(rd_val[0]));
		{below, above} <= 2'b01;
		for (n = 0; n < 80 && chip_rst !== 1'b0; n++)
			@(posedge clk);
		chk("release", 32'h0, 32'(chip_rst));
		repeat (6) @(posedge clk);
		rd(`LVIL_OFS_STATUS);
		chk("flag_clr", 32'h0, 32'(rd_val[0]));
		{above, stopm, run_cpu} <= 3'b001;
	endtask
	task automatic final_report;
		$display("Comparisons %0d mismatches %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ********
	// Tests
	// ********
	initial
	begin
		#200us;
		miscompares++;
		final_report();
	end
	initial
	begin
		{seed, rst, run_cpu, cpu, xtal, waitm, stopm, sysr, below, above} = {32'h3898, 9'h180};
		{awvalid, wvalid, bready, arvalid, rready, awaddr, araddr} = 21'h0;
		clken = 1'b1;
		{wdata, wstrb, miscompares, compares} = {32'h0, 4'hF, 64'h0};
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		rd(`LVIL_OFS_CONFIG);
		chk("cfg", {29'h0, `LVIL_CFG_RESET}, rd_val);
		rd(`LVIL_OFS_MASK);
		chk("mask", 32'h0, rd_val);
		rd(8'h10);
		chk("bad_rd", {30'h0, `LVIL_RESP_SLVERR}, {rd_val[29:0], resp});
		wr(8'h10, 32'h7);
		chk("bad_wr", 32'(`LVIL_RESP_SLVERR), 32'(resp));
		wstrb <= 4'h0;
		wr(`LVIL_OFS_CONFIG, 32'h0);
		wstrb <= 4'hF;
		rd(`LVIL_OFS_CONFIG);
		chk("strb", 32'h3, rd_val);
		for (int i = 0; i < 16; i++)
			trip(3'(i), i[3]);
		chk("irq_masked", 32'h0, 32'(irq));
		wr(`LVIL_OFS_CONFIG, 32'h3);
		repeat (20)
		begin
			below <= 1'b1;
			repeat (1 + 3'($random(seed))) @(posedge clk);
			below <= 1'b0;
			repeat (6) @(posedge clk);
		end
		chk("glitch", 32'h0, 32'(chip_rst));
		// A frozen block must not count a low supply
		{clken, below} <= 2'b01;
		repeat (40) @(posedge clk);
		chk("freeze", 32'h0, 32'(chip_rst));
		{clken, below} <= 2'b10;
		repeat (6) @(posedge clk);
		wr(`LVIL_OFS_CONFIG, 32'h1);
		below <= 1'b1;
		for (n = 0; n < 24; n += int'(xtal))
			@(posedge clk);
		below <= 1'b0;
		repeat (6) @(posedge clk);
		rd(`LVIL_OFS_STATUS);
		chk("flag_short", 32'h0, 32'(rd_val[0]));
		below <= 1'b1;
		repeat (100) @(posedge clk);
		below <= 1'b0;
		repeat (6) @(posedge clk);
		rd(`LVIL_OFS_STATUS);
		chk("flag_hold", 32'h1, 32'(rd_val[0]));
		sysr <= 1'b1;
		@(posedge clk);
		sysr <= 1'b0;
		rd(`LVIL_OFS_STATUS);
		chk("flag_sys", 32'h0, 32'(rd_val[0]));
		rd(`LVIL_OFS_EVENT);
		wr(`LVIL_OFS_MASK, 32'h1);
		trip(3'h3, 1'b0);
		chk("irq", 32'h1, 32'(irq));
		rd(`LVIL_OFS_EVENT);
		chk("event", 32'h5, rd_val & 32'h5);
		repeat (2) @(posedge clk);
		chk("irq_clr", 32'h0, 32'(irq));
		final_report();
	end
endmodule
bind lvil_core lvil_monitor #(.FILTER_CYCLES(FILTER_CYCLES)) u_mon (.ref_clk_i, .rst_i, .clk_en_i,
	.cpu_cycle_i, .stop_mode_i, .below_falling_i, .above_rising_i, .monitor_power_o, .chip_reset_o,
	.reset_pin_o, .reset_pin_oe_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_rdata_o,
	.s_axi_rvalid_o, .s_axi_rready_i);
`default_nettype wire
